// >>> shared/nfc_pkg.sv
package nfc_pkg;
   // ------------------------------------------------------------
   // Sizes and timing
   // ------------------------------------------------------------
   localparam int          FIFO_DEPTH = 512;
   localparam int          FIFO_AW    = 9;
   localparam int          DATA_W     = 8;
   localparam int          LEN_W      = 13;
   localparam int          CNT_W      = 10;
   localparam int          DIV_W      = 8;
   localparam logic [7:0]  BASE_DIV   = 8'h04;
   localparam logic [15:0] CRC_POLY   = 16'h1021;
   localparam logic [15:0] CRC_INIT   = 16'hFFFF;
   localparam logic        PAR_INIT   = 1'b1;

   // ------------------------------------------------------------
   // Modes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {NFC_XFER_FRAMED, NFC_XFER_STREAM, NFC_XFER_TRANSP} nfc_xfer_t;
   typedef enum logic [1:0] {NFC_RF_A, NFC_RF_B, NFC_RF_F, NFC_RF_V} nfc_rf_t;

   // One serial CRC step, MSB-first shift register
   function automatic logic [15:0] nfc_crc_step(input logic [15:0] crc, input logic b);
      nfc_crc_step = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? CRC_POLY : 16'h0000);
   endfunction : nfc_crc_step
endpackage : nfc_pkg

// >>> design/nfc_fifo_mem.sv
module nfc_fifo_mem (
   // Clock
   input  wire logic                         mclk,
   // Write port
   input  wire logic                         we,
   input  wire logic [nfc_pkg::FIFO_AW-1:0]  waddr,
   input  wire logic [nfc_pkg::DATA_W-1:0]   wdata,
   // Read port
   input  wire logic                         re,
   input  wire logic [nfc_pkg::FIFO_AW-1:0]  raddr,
   output logic      [nfc_pkg::DATA_W-1:0]   rdata_q
);
   logic [nfc_pkg::DATA_W-1:0] mem [nfc_pkg::FIFO_DEPTH];

   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      if (re) begin
         rdata_q <= mem[raddr];
      end
   end
endmodule : nfc_fifo_mem

// >>> design/nfc_codec.sv
module nfc_codec (
   // Clock and reset
   input  wire logic                        mclk,
   input  wire logic                        srst,
   // Configuration
   input  wire logic                        i2c_select,
   input  wire logic                        op_enable,
   input  wire logic                        tx_enable,
   input  wire logic                        rx_enable,
   input  wire logic [1:0]                  tx_mode,
   input  wire logic [1:0]                  rx_mode,
   input  wire logic [1:0]                  rf_mode,
   input  wire logic [1:0]                  bit_rate,
   // Host pins and protocol engine
   input  wire logic                        serial_port_select_n,
   input  wire logic                        mosi,
   input  wire logic                        host_out_bit,
   input  wire logic                        host_sda_low,
   output logic                             miso_out_q,
   output logic                             miso_oe_q,
   // Host FIFO access
   input  wire logic                        host_wr,
   input  wire logic [7:0]                  host_wdata,
   input  wire logic                        host_rd,
   output logic      [7:0]                  host_rdata_q,
   output logic                             host_rvalid_q,
   output logic                             host_err_q,
   output logic      [nfc_pkg::CNT_W-1:0]   fifo_count_q,
   // Transmit
   input  wire logic                        tx_start,
   input  wire logic [nfc_pkg::LEN_W-1:0]   tx_len,
   output logic                             tx_mod_q,
   output logic                             tx_busy_q,
   // Receive
   input  wire logic                        rx_sof,
   input  wire logic                        rx_eof,
   input  wire logic                        rx_bit_valid,
   input  wire logic                        rx_bit,
   input  wire logic                        rx_subc,
   output logic                             rx_busy_q,
   output logic                             rx_done_q,
   output logic                             rx_par_err_q,
   output logic                             rx_crc_ok_q
);
   typedef enum logic [2:0] {TX_IDLE, TX_SOF, TX_FETCH, TX_WAIT, TX_BITS, TX_PAR, TX_CRC,
                             TX_EOF} nfc_tx_st_t;

   // ------------------------------------------------------------
   // Strap capture and bit-rate divider
   // ------------------------------------------------------------
   logic             i2c_q, i2c_d, cap_q, cap_d;
   logic [7:0]       div_q, div_d;
   logic             tick;
   logic [7:0]       div_max;
   always_comb begin
      cap_d   = 1'b1;
      i2c_d   = cap_q ? i2c_q : i2c_select;
      div_max = 8'(nfc_pkg::BASE_DIV << bit_rate) - 8'h01;
      // Range compare: a switch to a faster rate must not wait for wraparound
      tick    = (div_q >= div_max);
      div_d   = tick ? 8'h00 : div_q + 8'h01;
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         cap_q <= 1'b0;
         i2c_q <= 1'b0;
         div_q <= 8'h00;
      end else begin
         cap_q <= cap_d;
         i2c_q <= i2c_d;
         div_q <= div_d;
      end
   end

   // ------------------------------------------------------------
   // Shared FIFO
   // ------------------------------------------------------------
   logic [8:0] wp_q, wp_d, rp_q, rp_d;
   logic [nfc_pkg::CNT_W-1:0] cnt_d;
   logic       we, re, host_wr_ok, host_rd_ok, tx_pop, rx_push_q, full, empty;
   logic       hsel_q, err_d;
   logic [7:0] rx_byte_q, wdata, mem_q;
   always_comb begin
      full       = (fifo_count_q == 10'(nfc_pkg::FIFO_DEPTH));
      empty      = (fifo_count_q == 10'h000);
      host_wr_ok = host_wr & op_enable & ~rx_push_q & ~full;
      we         = host_wr_ok | (rx_push_q & ~full);
      wdata      = rx_push_q ? rx_byte_q : host_wdata;
      host_rd_ok = host_rd & op_enable & ~tx_pop & ~empty;
      re         = tx_pop | host_rd_ok;
      err_d      = (host_wr & ~host_wr_ok) | (host_rd & ~host_rd_ok);
      wp_d       = we ? wp_q + 9'h001 : wp_q;
      rp_d       = re ? rp_q + 9'h001 : rp_q;
      cnt_d      = fifo_count_q + {9'h000, we} - {9'h000, re};
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         wp_q <= 9'h000;
         rp_q <= 9'h000;
         fifo_count_q <= 10'h000;
         hsel_q <= 1'b0;
         host_rvalid_q <= 1'b0;
         host_rdata_q <= 8'h00;
         host_err_q <= 1'b0;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         fifo_count_q <= cnt_d;
         hsel_q <= host_rd_ok;
         host_rvalid_q <= hsel_q;
         host_rdata_q <= hsel_q ? mem_q : host_rdata_q;
         host_err_q <= err_d;
      end
   end

   nfc_fifo_mem u_mem (
      .mclk    (mclk),
      .we      (we),
      .waddr   (wp_q),
      .wdata   (wdata),
      .re      (re),
      .raddr   (rp_q),
      .rdata_q (mem_q)
   );

   // ------------------------------------------------------------
   // Transmit encoder
   // ------------------------------------------------------------
   nfc_tx_st_t  ts_q, ts_d;
   logic [7:0]  tsh_q, tsh_d;
   logic [3:0]  tcnt_q, tcnt_d;
   logic [12:0] tleft_q, tleft_d;
   logic [15:0] tcrc_q, tcrc_d;
   logic        tpar_q, tpar_d, mod_d, framed, par_en, tx_on;
   always_comb begin
      ts_d = ts_q;
      tsh_d = tsh_q;
      tcnt_d = tcnt_q;
      tleft_d = tleft_q;
      tcrc_d = tcrc_q;
      tpar_d = tpar_q;
      mod_d = tx_mod_q;
      tx_pop = 1'b0;
      tx_on = tx_enable & op_enable;
      framed = (tx_mode == nfc_pkg::NFC_XFER_FRAMED);
      par_en = (rf_mode == nfc_pkg::NFC_RF_A);
      case (ts_q)
         TX_IDLE: begin
            if (tx_on && tx_mode == nfc_pkg::NFC_XFER_TRANSP) begin
               mod_d = mosi;
            end else if (tx_on && tx_start && framed && tx_len != 13'h0000) begin
               ts_d = TX_SOF;
               tleft_d = tx_len;
               tcrc_d = nfc_pkg::CRC_INIT;
            end else if (tx_on && tx_start && tx_mode == nfc_pkg::NFC_XFER_STREAM) begin
               ts_d = TX_FETCH;
            end
         end
         TX_SOF: begin
            if (tick) begin
               mod_d = 1'b1;
               ts_d = TX_FETCH;
            end
         end
         TX_FETCH: begin
            // Framed transfers stall on an empty FIFO; stream ends there
            if (!empty) begin
               tx_pop = 1'b1;
               ts_d = TX_WAIT;
            end else if (!framed) begin
               ts_d = TX_IDLE;
            end
         end
         TX_WAIT: begin
            tsh_d = mem_q;
            tcnt_d = 4'h0;
            tpar_d = nfc_pkg::PAR_INIT;
            ts_d = TX_BITS;
         end
         TX_BITS: begin
            if (tick) begin
               mod_d = tsh_q[0];
               tsh_d = {1'b0, tsh_q[7:1]};
               tpar_d = tpar_q ^ tsh_q[0];
               tcrc_d = framed ? nfc_pkg::nfc_crc_step(tcrc_q, tsh_q[0]) : tcrc_q;
               tcnt_d = tcnt_q + 4'h1;
               if (tcnt_q == 4'h7) begin
                  tleft_d = tleft_q - 13'h0001;
                  if (framed && par_en) begin
                     ts_d = TX_PAR;
                  end else if (framed && tleft_q == 13'h0001) begin
                     ts_d = TX_CRC;
                     tcnt_d = 4'h0;
                  end else begin
                     ts_d = TX_FETCH;
                  end
               end
            end
         end
         TX_PAR: begin
            if (tick) begin
               mod_d = tpar_q;
               tcnt_d = 4'h0;
               ts_d = (tleft_q == 13'h0000) ? TX_CRC : TX_FETCH;
            end
         end
         TX_CRC: begin
            if (tick) begin
               mod_d = tcrc_q[15];
               tcrc_d = {tcrc_q[14:0], 1'b0};
               tcnt_d = tcnt_q + 4'h1;
               ts_d = (tcnt_q == 4'hF) ? TX_EOF : TX_CRC;
            end
         end
         TX_EOF: begin
            if (tick) begin
               mod_d = 1'b0;
               ts_d = TX_IDLE;
            end
         end
         default: ts_d = TX_IDLE;
      endcase
      if (!tx_on) begin
         ts_d = TX_IDLE;
         mod_d = 1'b0;
         tx_pop = 1'b0;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         ts_q <= TX_IDLE;
         tsh_q <= 8'h00;
         tcnt_q <= 4'h0;
         tleft_q <= 13'h0000;
         tcrc_q <= nfc_pkg::CRC_INIT;
         tpar_q <= nfc_pkg::PAR_INIT;
         tx_mod_q <= 1'b0;
         tx_busy_q <= 1'b0;
      end else begin
         ts_q <= ts_d;
         tsh_q <= tsh_d;
         tcnt_q <= tcnt_d;
         tleft_q <= tleft_d;
         tcrc_q <= tcrc_d;
         tpar_q <= tpar_d;
         tx_mod_q <= mod_d;
         tx_busy_q <= (ts_d != TX_IDLE);
      end
   end

   // ------------------------------------------------------------
   // Receive decoder
   // ------------------------------------------------------------
   logic [7:0]  rsh_q, rsh_d;
   logic [3:0]  rcnt_q, rcnt_d;
   logic [15:0] rcrc_q, rcrc_d;
   logic        rpar_q, rpar_d, rbusy_d, push_d, done_d, perr_d, crc_ok_d;
   logic        rx_on, rx_stream, rx_transp;
   always_comb begin
      rsh_d = rsh_q;
      rcnt_d = rcnt_q;
      rcrc_d = rcrc_q;
      rpar_d = rpar_q;
      rbusy_d = rx_busy_q;
      perr_d = rx_par_err_q;
      crc_ok_d = rx_crc_ok_q;
      push_d = 1'b0;
      done_d = 1'b0;
      rx_on = rx_enable & op_enable;
      rx_stream = rx_on & (rx_mode == nfc_pkg::NFC_XFER_STREAM);
      rx_transp = rx_on & (rx_mode == nfc_pkg::NFC_XFER_TRANSP);
      if (rx_stream) begin
         rbusy_d = 1'b1;
         if (tick) begin
            rsh_d = {rx_subc, rsh_q[7:1]};
            rcnt_d = (rcnt_q == 4'h7) ? 4'h0 : rcnt_q + 4'h1;
            push_d = (rcnt_q == 4'h7);
         end
      end else if (!rx_on || rx_mode != nfc_pkg::NFC_XFER_FRAMED) begin
         rbusy_d = 1'b0;
         rcnt_d = 4'h0;
      end else if (!rx_busy_q) begin
         if (rx_sof) begin
            rbusy_d = 1'b1;
            rcnt_d = 4'h0;
            rcrc_d = nfc_pkg::CRC_INIT;
            rpar_d = nfc_pkg::PAR_INIT;
            perr_d = 1'b0;
            crc_ok_d = 1'b0;
         end
      end else if (rx_eof) begin
         rbusy_d = 1'b0;
         done_d = 1'b1;
         crc_ok_d = (rcrc_q == 16'h0000);
      end else if (rx_bit_valid) begin
         if (rcnt_q == 4'h8) begin
            perr_d = rx_par_err_q | (rx_bit != rpar_q);
            push_d = 1'b1;
            rcnt_d = 4'h0;
            rpar_d = nfc_pkg::PAR_INIT;
         end else begin
            rsh_d = {rx_bit, rsh_q[7:1]};
            rcrc_d = nfc_pkg::nfc_crc_step(rcrc_q, rx_bit);
            rpar_d = rpar_q ^ rx_bit;
            rcnt_d = rcnt_q + 4'h1;
            if (rcnt_q == 4'h7 && rf_mode != nfc_pkg::NFC_RF_A) begin
               push_d = 1'b1;
               rcnt_d = 4'h0;
               rpar_d = nfc_pkg::PAR_INIT;
            end
         end
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         rsh_q <= 8'h00;
         rcnt_q <= 4'h0;
         rcrc_q <= nfc_pkg::CRC_INIT;
         rpar_q <= nfc_pkg::PAR_INIT;
         rx_busy_q <= 1'b0;
         rx_push_q <= 1'b0;
         rx_byte_q <= 8'h00;
         rx_done_q <= 1'b0;
         rx_par_err_q <= 1'b0;
         rx_crc_ok_q <= 1'b0;
      end else begin
         rsh_q <= rsh_d;
         rcnt_q <= rcnt_d;
         rcrc_q <= rcrc_d;
         rpar_q <= rpar_d;
         rx_busy_q <= rbusy_d;
         rx_push_q <= push_d;
         rx_byte_q <= push_d ? rsh_d : rx_byte_q;
         rx_done_q <= done_d;
         rx_par_err_q <= perr_d;
         rx_crc_ok_q <= crc_ok_d;
      end
   end

   // ------------------------------------------------------------
   // Shared data pin
   // ------------------------------------------------------------
   logic mo_d, moe_d;
   always_comb begin
      if (rx_transp) begin
         mo_d = rx_subc;
         moe_d = 1'b1;
      end else if (i2c_q) begin
         mo_d = 1'b0;
         moe_d = host_sda_low;
      end else begin
         mo_d = host_out_bit;
         moe_d = ~serial_port_select_n;
      end
   end
   always_ff @(posedge mclk) begin
      if (srst) begin
         miso_out_q <= 1'b0;
         miso_oe_q <= 1'b0;
      end else begin
         miso_out_q <= mo_d;
         miso_oe_q <= moe_d;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (srst);
   chk_transp_tx_mod: assert property (
      ts_q == TX_IDLE && tx_on && tx_mode == nfc_pkg::NFC_XFER_TRANSP |=> tx_mod_q == $past(mosi))
      else $error("transparent tx does not follow mosi");
   chk_pdown_block: assert property ((host_wr || host_rd) && !op_enable |=> host_err_q)
      else $error("fifo access not refused in power-down");
   chk_fifo_bound: assert property (fifo_count_q <= 10'(nfc_pkg::FIFO_DEPTH))
      else $error("fifo count beyond depth");
   chk_rd_latency: assert property (host_rd_ok |-> ##2 host_rvalid_q)
      else $error("host read data late");
   chk_transp_rx_pin: assert property (
      rx_transp |=> miso_oe_q && miso_out_q == $past(rx_subc))
      else $error("transparent rx not on pin");
   chk_spi_oe: assert property (
      !rx_transp && !i2c_q |=> miso_oe_q == !$past(serial_port_select_n))
      else $error("spi output enable wrong");
   chk_i2c_drive: assert property (!rx_transp && i2c_q |=> !miso_out_q)
      else $error("i2c data driven high");
   chk_strap_hold: assert property (cap_q && $past(cap_q) |-> $stable(i2c_q))
      else $error("strap changed after capture");
   chk_tx_off_idle: assert property (!tx_on |=> !tx_busy_q && !tx_mod_q)
      else $error("tx active while disabled");
   chk_sof_first: assert property (
      ts_q == TX_SOF && tick && tx_on |=> tx_mod_q && ts_q == TX_FETCH)
      else $error("start of frame missing");
   cov_tx_frame: cover property (ts_q == TX_EOF && tick);
   cov_rx_crc: cover property (rx_done_q && rx_crc_ok_q);
   cov_fifo_full: cover property (full);
   cov_stream_rx: cover property (rx_stream && rx_push_q);
endmodule : nfc_codec

// >>> sim/nfc_host_model.sv
module nfc_host_model (
   // Clock
   input  wire logic       mclk,
   // Strap and serial pins
   output logic            i2c_select,
   output logic            serial_port_select_n,
   output logic            mosi,
   output logic            host_out_bit,
   output logic            host_sda_low,
   // FIFO access
   output logic            host_wr,
   output logic [7:0]      host_wdata,
   output logic            host_rd,
   input  wire logic [7:0] host_rdata_q,
   input  wire logic       host_rvalid_q,
   input  wire logic       host_err_q
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      i2c_select           = 1'b0;
      serial_port_select_n = 1'b1;
      mosi                 = 1'b0;
      host_out_bit         = 1'b0;
      host_sda_low         = 1'b0;
      host_wr              = 1'b0;
      host_wdata           = 8'h00;
      host_rd              = 1'b0;
   end

   // Strap only moves while the block is held in reset
   task automatic strap(input logic v);
      i2c_select = v;
   endtask : strap

   task automatic pins(input logic sel_n, input logic ob, input logic sda, input logic m);
      @(negedge mclk);
      serial_port_select_n = sel_n;
      host_out_bit         = ob;
      host_sda_low         = sda;
      mosi                 = m;
   endtask : pins

   task automatic put(input logic [7:0] b, output logic err);
      @(negedge mclk);
      host_wr    = 1'b1;
      host_wdata = b;
      @(negedge mclk);
      // Refusal flag stands only in the cycle after the taking edge
      err        = host_err_q;
      host_wr    = 1'b0;
      // Released data bus shows garbage, not the old byte
      host_wdata = ~b;
   endtask : put

   task automatic get(output logic [7:0] b, output logic err, output logic vld);
      @(negedge mclk);
      host_rd = 1'b1;
      @(negedge mclk);
      err     = host_err_q;
      host_rd = 1'b0;
      @(negedge mclk);
      vld = host_rvalid_q;
      b   = host_rdata_q;
   endtask : get
endmodule : nfc_host_model

// >>> sim/nfc_codec_test.sv
module nfc_codec_test;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   localparam int LIMIT = 30000;
   logic       mclk, srst, i2c_select, op_enable, tx_enable, rx_enable;
   logic [1:0] tx_mode, rx_mode, rf_mode, bit_rate;
   logic       serial_port_select_n, mosi, host_out_bit, host_sda_low;
   logic       miso_out_q, miso_oe_q, host_wr, host_rd, host_rvalid_q, host_err_q;
   logic [7:0] host_wdata, host_rdata_q;
   logic [nfc_pkg::CNT_W-1:0] fifo_count_q;
   logic       tx_start, tx_mod_q, tx_busy_q;
   logic [nfc_pkg::LEN_W-1:0] tx_len;
   logic       rx_sof, rx_eof, rx_bit_valid, rx_bit, rx_subc;
   logic       rx_busy_q, rx_done_q, rx_par_err_q, rx_crc_ok_q;
   int         n_errors, n_checks, cycles;
   logic       q[$];
   logic [7:0] b;
   logic       e, v;

   nfc_codec u_dut (.mclk, .srst, .i2c_select, .op_enable, .tx_enable, .rx_enable,
      .tx_mode, .rx_mode, .rf_mode, .bit_rate, .serial_port_select_n, .mosi,
      .host_out_bit, .host_sda_low, .miso_out_q, .miso_oe_q, .host_wr, .host_wdata,
      .host_rd, .host_rdata_q, .host_rvalid_q, .host_err_q, .fifo_count_q, .tx_start,
      .tx_len, .tx_mod_q, .tx_busy_q, .rx_sof, .rx_eof, .rx_bit_valid, .rx_bit, .rx_subc,
      .rx_busy_q, .rx_done_q, .rx_par_err_q, .rx_crc_ok_q);

   nfc_host_model u_host (.mclk, .i2c_select, .serial_port_select_n, .mosi, .host_out_bit,
      .host_sda_low, .host_wr, .host_wdata, .host_rd, .host_rdata_q, .host_rvalid_q,
      .host_err_q);

   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : final_report

   task automatic rst(input logic s);
      srst = 1'b1;
      u_host.strap(s);
      repeat (10) @(negedge mclk);
      srst = 1'b0;
      @(negedge mclk);
   endtask : rst

   // Data bits LSB first, optional odd parity, then CRC MSB first
   task automatic build(input logic [7:0] d, input logic par);
      logic [15:0] crc;
      crc = nfc_pkg::CRC_INIT;
      q = {};
      for (int i = 0; i < 8; i++) begin
         q.push_back(d[i]);
         crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ d[i]) ? nfc_pkg::CRC_POLY : 16'h0000);
      end
      if (par) q.push_back(~^d);
      for (int i = 15; i >= 0; i--) q.push_back(crc[i]);
   endtask : build

   task automatic idle_wait;
      for (int k = 0; k < 1200 && tx_busy_q !== 1'b0; k++) @(negedge mclk);
   endtask : idle_wait

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_fifo;
      op_enable = 1'b0;
      check(fifo_count_q, 16'h0000);
      u_host.put(8'h11, e);
      check(e, 1'b1);
      check(fifo_count_q, 16'h0000);
      op_enable = 1'b1;
      u_host.put(8'h5A, e);
      u_host.put(8'hE7, e);
      check(fifo_count_q, 16'h0002);
      u_host.get(b, e, v);
      check({v, b}, 16'h015A);
      u_host.get(b, e, v);
      check({v, b}, 16'h01E7);
      u_host.get(b, e, v);
      check(e, 1'b1);
      $display("test fifo done");
   endtask : t_fifo

   task automatic t_txf(input logic [1:0] rf, input logic [7:0] d, input int nchk);
      logic exp_q[$];
      int   per;
      per = 4 << rf;
      build(d, rf == 2'd0);
      exp_q = {1'b1, q, 1'b0};
      u_host.put(d, e);
      rf_mode   = rf;
      bit_rate  = rf;
      tx_mode   = 2'd0;
      tx_len    = 13'h0001;
      tx_start  = 1'b1;
      @(negedge mclk);
      tx_start = 1'b0;
      check(tx_busy_q, 1'b1);
      for (int k = 0; k < 200 && tx_mod_q !== 1'b1; k++) @(negedge mclk);
      repeat (per / 2 - 1) @(negedge mclk);
      for (int i = 0; i < nchk; i++) begin
         check(tx_mod_q, exp_q[i]);
         repeat (per) @(negedge mclk);
      end
      idle_wait();
      check(tx_busy_q, 1'b0);
      $display("test framed tx done");
   endtask : t_txf

   task automatic t_txs;
      u_host.put(8'hA5, e);
      bit_rate = 2'd1;
      tx_mode  = 2'd1;
      tx_start = 1'b1;
      @(negedge mclk);
      tx_start = 1'b0;
      for (int k = 0; k < 200 && tx_mod_q !== 1'b1; k++) @(negedge mclk);
      repeat (3) @(negedge mclk);
      for (int i = 0; i < 8; i++) begin
         check(tx_mod_q, 8'hA5 >> i & 1);
         repeat (8) @(negedge mclk);
      end
      idle_wait();
      check(tx_busy_q, 1'b0);
      tx_mode = 2'd2;
      for (int i = 0; i < 4; i++) begin
         u_host.pins(1'b0, 1'b0, 1'b0, i[0]);
         @(negedge mclk);
         check(tx_mod_q, i[0]);
      end
      tx_mode = 2'd3;
      $display("test stream and transparent tx done");
   endtask : t_txs

   task automatic t_rxf(input logic [1:0] rf, input logic bad);
      logic [7:0] eb;
      build(8'h3C, rf == 2'd0);
      if (bad) q[8] = ~q[8];
      rf_mode   = rf;
      rx_mode   = 2'd0;
      rx_enable = 1'b1;
      tx_enable = 1'b0;
      rx_sof    = 1'b1;
      @(negedge mclk);
      rx_sof = 1'b0;
      check(rx_busy_q, 1'b1);
      foreach (q[i]) begin
         rx_bit       = q[i];
         rx_bit_valid = 1'b1;
         @(negedge mclk);
         rx_bit_valid = 1'b0;
         rx_bit       = ~q[i];
         @(negedge mclk);
      end
      repeat (3) @(negedge mclk);
      rx_eof = 1'b1;
      @(negedge mclk);
      rx_eof = 1'b0;
      check(rx_done_q, 1'b1);
      if (bad) begin
         check(rx_par_err_q, 1'b1);
      end else begin
         check({rx_crc_ok_q, fifo_count_q}, 16'h0403);
         for (int i = 0; i < 3; i++) begin
            for (int j = 0; j < 8; j++) eb[j] = q[8 * i + j];
            u_host.get(b, e, v);
            check(b, eb);
         end
      end
      tx_enable = 1'b1;
      $display("test framed rx done");
   endtask : t_rxf

   task automatic t_rxs;
      rx_subc = 1'b1;
      rx_mode = 2'd1;
      for (int k = 0; k < 400 && fifo_count_q === 0; k++) @(negedge mclk);
      rx_mode = 2'd3;
      u_host.get(b, e, v);
      check(b, 8'hFF);
      rx_mode = 2'd2;
      for (int i = 0; i < 4; i++) begin
         rx_subc = i[0];
         @(negedge mclk);
         check({miso_oe_q, miso_out_q}, {1'b1, i[0]});
      end
      rx_mode = 2'd3;
      $display("test stream and transparent rx done");
   endtask : t_rxs

   task automatic t_pins(input logic i2c);
      u_host.pins(1'b0, 1'b1, 1'b0, 1'b0);
      @(negedge mclk);
      check({miso_oe_q, miso_out_q}, i2c ? 2'b00 : 2'b11);
      u_host.pins(1'b1, 1'b1, 1'b1, 1'b0);
      @(negedge mclk);
      check({miso_oe_q, miso_out_q}, i2c ? 2'b10 : 2'b01);
      $display("test pin mux done");
   endtask : t_pins

   // ------------------------------------------------------------
   // Main sequence and hang guard
   // ------------------------------------------------------------
   initial begin
      {srst, op_enable, tx_enable, rx_enable, tx_mode, rx_mode, rf_mode, bit_rate} = '0;
      {tx_start, tx_len, rx_sof, rx_eof, rx_bit_valid, rx_bit, rx_subc} = '0;
      n_errors = 0;
      n_checks = 0;
      rst(1'b0);
      check({tx_busy_q, rx_busy_q, miso_oe_q, host_err_q}, 4'h0);
      t_fifo();
      tx_enable = 1'b1;
      for (int rf = 0; rf < 4; rf++) t_txf(rf[1:0], 8'hC3 + rf[7:0], rf == 0 ? 27 : 26);
      t_txs();
      t_rxf(2'd1, 1'b0);
      t_rxs();
      t_pins(1'b0);
      t_rxf(2'd0, 1'b1);
      rst(1'b1);
      t_pins(1'b1);
      final_report();
   end

   initial begin
      cycles = 0;
      forever begin
         @(posedge mclk);
         cycles++;
         if (cycles == LIMIT) begin
            n_errors++;
            $display("unexpected at %0t: run did not finish", $time);
            final_report();
         end
      end
   end
endmodule : nfc_codec_test
